/* File: fdma_pkg.sv */
/*
  Shared constants and types of the four-channel background copy engine.
  Assumes that every file of the engine imports this package whole.
*/
package fdma_pkg;

  // --------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------
  localparam int N_CH = 4;
  localparam int CH_W = 2;
  localparam int N_EVT = 20;
  localparam int EVT_SEL_W = 5;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int COUNT_W = 16;
  localparam int BUF_DEPTH = 2;

  // --------------------------------------------------------------
  // Reset values and the count of one
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CH_W-1:0] CH_RST = 2'h3;

  typedef enum logic [1:0] {
    FDMA_IDLE,
    FDMA_READ,
    FDMA_WRITE
  } fdma_state_t;

endpackage

/* File: fdma_stream_if.sv */
/*
  Valid/ready word stream used between the engine and its buffer.
  Assumes source and sink run on the same clock.
*/
`timescale 1ns/1ns
interface fdma_stream_if;
  import fdma_pkg::*;
  logic valid;
  logic ready;
  logic [DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: fdma_buf.sv */
/*
  Two-entry word buffer between the read and write phases of a copy.
  Assumes both sides share clk; ready on the filling side stalls the engine.
*/
`timescale 1ns/1ns
module fdma_buf
  import fdma_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  fdma_stream_if.snk in_s,
  fdma_stream_if.src out_s
);
  logic [DATA_W-1:0] mem_reg [BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] fill_reg;
  logic [1:0] fill_next;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;

  assign in_s.ready = (fill_reg != 2'h2);
  assign out_s.valid = (fill_reg != 2'h0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  assign fill_next = fill_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      fill_reg <= fill_next;
    end
  end

  for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_entry
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        mem_reg[e] <= DATA_RST;
      end else if (push && wr_ptr_reg == 1'(e)) begin
        mem_reg[e] <= in_s.data;
      end
    end
  end
endmodule

/* File: fdma_sync.sv */
/*
  Per-channel event selection and rising-edge pending flags.
  Assumes events come from logic on clk, so they are not resynchronised.
*/
`timescale 1ns/1ns
module fdma_sync
  import fdma_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N_EVT-1:0] sync_event,
  input wire logic [N_CH-1:0][EVT_SEL_W-1:0] channel_sync_event_select,
  input wire logic [N_CH-1:0] consume,
  output logic [N_CH-1:0] pending
);
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    logic prev_reg;
    logic pend_reg;
    wire [EVT_SEL_W-1:0] sel = channel_sync_event_select[c];
    // Codes beyond the last event select nothing, so the channel simply waits.
    wire level = (sel < EVT_SEL_W'(N_EVT)) ? sync_event[sel] : 1'b0;
    wire rise = level && !prev_reg;
    // An edge landing in the consuming cycle is kept: set beats clear.
    wire pend_next = rise || (pend_reg && !consume[c]);
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        prev_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else begin
        prev_reg <= level;
        pend_reg <= pend_next;
      end
    end
    assign pending[c] = pend_reg;
  end
endmodule

/* File: fdma_ctrl.sv */
/*
  Four-channel background copy engine: one memory master port, per-channel
  contexts, event synchronisation, ping-pong destinations and completion pulses.
  Assumes the channel settings come from software-written registers on clk,
  that the memory port answers each request with a one-cycle mem_ack, and that
  the clock is gated outside only after idle_ack is high.
*/
`timescale 1ns/1ns
module fdma_ctrl
  import fdma_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N_EVT-1:0] sync_event,
  input wire logic [N_CH-1:0] cfg_start,
  input wire logic [N_CH-1:0] cfg_sync_en,
  input wire logic [N_CH-1:0] cfg_pingpong,
  input wire logic [N_CH-1:0][EVT_SEL_W-1:0] channel_sync_event_select,
  input wire logic [N_CH-1:0][ADDR_W-1:0] cfg_src_addr,
  input wire logic [N_CH-1:0][ADDR_W-1:0] cfg_dst_addr,
  input wire logic [N_CH-1:0][ADDR_W-1:0] cfg_dst_addr_b,
  input wire logic [N_CH-1:0][COUNT_W-1:0] cfg_count,
  input wire logic clk_idle_req,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic [N_CH-1:0] chan_irq,
  output logic [N_CH-1:0] chan_active,
  output logic [N_CH-1:0] chan_half,
  output logic idle_ack
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fdma_state_t state_reg;
  fdma_state_t state_next;
  logic [CH_W-1:0] cur_ch_reg;
  logic [CH_W-1:0] pick;
  logic pick_ok;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [DATA_W-1:0] mem_wdata_reg;
  logic idle_ack_reg;
  logic [N_CH-1:0] pending;
  logic [N_CH-1:0] eligible;
  logic [N_CH-1:0] consume;
  logic [N_CH-1:0] act_w;
  logic [N_CH-1:0] half_w;
  logic [N_CH-1:0] irq_w;
  logic [N_CH-1:0][ADDR_W-1:0] src_w;
  logic [N_CH-1:0][ADDR_W-1:0] dst_w;
  logic [N_CH-1:0] last_w;

  fdma_stream_if rd_s ();
  fdma_stream_if wr_s ();

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  fdma_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .sync_event(sync_event),
    .channel_sync_event_select(channel_sync_event_select),
    .consume(consume),
    .pending(pending)
  );

  fdma_buf u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_s(rd_s),
    .out_s(wr_s)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire ack_hit = mem_req_reg && mem_ack;
  wire in_idle = (state_reg == FDMA_IDLE);
  wire in_read = (state_reg == FDMA_READ);
  wire in_write = (state_reg == FDMA_WRITE);
  // A read is only started while the buffer can take its word.
  wire start_elem = in_idle && pick_ok && !clk_idle_req && rd_s.ready;
  wire load_write = in_write && !mem_req_reg && wr_s.valid;
  wire step_done = in_write && ack_hit;

  assign rd_s.valid = in_read && ack_hit;
  assign rd_s.data = mem_rdata;
  assign wr_s.ready = step_done;

  // A synced channel needs a pending edge; a free channel just runs.
  assign eligible = act_w & (~cfg_sync_en | pending);

  // Rotating priority starting after the channel served last.
  always_comb begin
    logic [CH_W-1:0] idx;
    idx = cur_ch_reg;
    pick = cur_ch_reg;
    pick_ok = 1'b0;
    for (int i = N_CH; i >= 1; i--) begin
      idx = cur_ch_reg + CH_W'(i);
      if (eligible[idx]) begin
        pick = idx;
        pick_ok = 1'b1;
      end
    end
  end

  for (genvar c = 0; c < N_CH; c++) begin : g_consume
    assign consume[c] = start_elem && cfg_sync_en[c] && (pick == CH_W'(c));
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FDMA_IDLE: begin
        if (start_elem) begin
          state_next = FDMA_READ;
        end
      end
      FDMA_READ: begin
        if (ack_hit) begin
          state_next = FDMA_WRITE;
        end
      end
      FDMA_WRITE: begin
        if (ack_hit) begin
          state_next = FDMA_IDLE;
        end
      end
      default: begin
        state_next = FDMA_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and memory master
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= FDMA_IDLE;
      cur_ch_reg <= CH_RST;
    end else begin
      state_reg <= state_next;
      if (start_elem) cur_ch_reg <= pick;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= ADDR_RST;
      mem_wdata_reg <= DATA_RST;
    end else if (start_elem) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= src_w[pick];
    end else if (load_write) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= 1'b1;
      mem_addr_reg <= dst_w[cur_ch_reg];
      mem_wdata_reg <= wr_s.data;
    end else if (ack_hit) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
    end
  end

  // Acknowledged only between elements, so gating never cuts a copy short.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_ack_reg <= 1'b0;
    end else begin
      idle_ack_reg <= clk_idle_req && in_idle && !start_elem;
    end
  end

  // ----------------------------------------------------------------
  // Channel contexts
  // ----------------------------------------------------------------
  // No parameter shapes this module, so every instance behaves alike.
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    logic act_reg;
    logic half_reg;
    logic irq_reg;
    logic [ADDR_W-1:0] src_reg;
    logic [ADDR_W-1:0] dst_reg;
    logic [COUNT_W-1:0] left_reg;
    wire mine = step_done && (cur_ch_reg == CH_W'(c));
    wire last = (left_reg == COUNT_ONE);
    wire load = cfg_start[c] && (cfg_count[c] != COUNT_RST) && !act_reg;
    // Next half's destination: after half A comes B and back again.
    wire [ADDR_W-1:0] dst_swap = half_reg ? cfg_dst_addr[c] : cfg_dst_addr_b[c];

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        act_reg <= 1'b0;
        half_reg <= 1'b0;
        src_reg <= ADDR_RST;
        dst_reg <= ADDR_RST;
        left_reg <= COUNT_RST;
      end else if (load) begin
        act_reg <= 1'b1;
        half_reg <= 1'b0;
        src_reg <= cfg_src_addr[c];
        dst_reg <= cfg_dst_addr[c];
        left_reg <= cfg_count[c];
      end else if (mine && last && cfg_pingpong[c]) begin
        half_reg <= ~half_reg;
        src_reg <= cfg_src_addr[c];
        dst_reg <= dst_swap;
        left_reg <= cfg_count[c];
      end else if (mine && last) begin
        act_reg <= 1'b0;
        left_reg <= COUNT_RST;
      end else if (mine) begin
        src_reg <= src_reg + 1'b1;
        dst_reg <= dst_reg + 1'b1;
        left_reg <= left_reg - 1'b1;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        irq_reg <= 1'b0;
      end else begin
        irq_reg <= mine && last;
      end
    end

    assign act_w[c] = act_reg;
    assign half_w[c] = half_reg;
    assign irq_w[c] = irq_reg;
    assign src_w[c] = src_reg;
    assign dst_w[c] = dst_reg;
    assign last_w[c] = last;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign chan_irq = irq_w;
  assign chan_active = act_w;
  assign chan_half = half_w;
  assign idle_ack = idle_ack_reg;
endmodule

/* File: fdma_ctrl_monitor.sv */
/*
  Port checker for the copy engine, bound to fdma_ctrl.
  Assumes one clock domain and sight of the top module's ports only.
*/
`timescale 1ns/1ns
module fdma_chk
  import fdma_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N_CH-1:0] cfg_start,
  input wire logic [N_CH-1:0][COUNT_W-1:0] cfg_count,
  input wire logic clk_idle_req,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [N_CH-1:0] chan_irq,
  input wire logic [N_CH-1:0] chan_active,
  input wire logic idle_ack
);
  logic [N_CH-1:0] launch;
  logic wr_done_reg;
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      launch[i] = cfg_start[i] && !chan_active[i] && !clk_idle_req && cfg_count[i] != COUNT_RST;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_done_reg <= 1'b0;
    end else begin
      wr_done_reg <= mem_req && mem_we && mem_ack;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_req_held_steady: assert property (
    mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata}))
    else $error("request changed before its acknowledge");
  a_req_drops_ack: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request stayed high after acknowledge");
  a_write_after_read: assert property (
    mem_req && mem_ack && !mem_we |=> !mem_req ##1 (mem_req && mem_we))
    else $error("write did not follow read by one idle cycle");
  a_quiet_when_idle: assert property (chan_active == 4'h0 |-> !mem_req)
    else $error("memory request with no channel active");
  a_launch_activates: assert property (
    launch != 4'h0 |=> (chan_active & $past(launch)) == $past(launch))
    else $error("started channel did not become active");
  a_irq_needs_write: assert property (
    chan_irq != 4'h0 |-> wr_done_reg && $onehot(chan_irq))
    else $error("completion pulse without a finished write");
  a_irq_single_pulse: assert property (
    chan_irq != 4'h0 |=> (chan_irq & $past(chan_irq)) == 4'h0)
    else $error("completion pulse longer than one cycle");
  a_idle_no_req: assert property (idle_ack |-> !mem_req)
    else $error("memory request while parked");
  a_idle_ack_cause: assert property ($rose(idle_ack) |-> $past(clk_idle_req))
    else $error("parked without a request");
endmodule
bind fdma_ctrl fdma_chk chk (.clk(clk), .reset_n(reset_n), .cfg_start(cfg_start),
  .cfg_count(cfg_count), .clk_idle_req(clk_idle_req), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .chan_irq(chan_irq),
  .chan_active(chan_active), .idle_ack(idle_ack));

/* File: fdma_mem_model.sv */
/*
  Behavioural memory behind the engine's master port.
  Assumes one request at a time; lat sets the wait cycles before each ack.
*/
`timescale 1ns/1ns
module fdma_mem_model
  import fdma_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  output logic mem_ack,
  output logic [DATA_W-1:0] mem_rdata
);
  logic [DATA_W-1:0] store [0:65535];
  logic [3:0] wait_reg;
  initial begin
    for (int a = 0; a < 65536; a++) begin
      store[a] = 16'(a) ^ 16'h5A5A;
    end
  end
  // Read data toggles outside the ack cycle so a sample one cycle late never looks right.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_reg == lat) begin
      mem_ack <= 1'b1;
      wait_reg <= 4'h0;
      mem_rdata <= store[mem_addr];
      if (mem_we) begin
        store[mem_addr] <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_reg <= (mem_req && !mem_ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: fdma_ctrl_bench.sv */
/*
  Self-checking bench for the copy engine with a memory model behind it.
  Assumes a 10 MHz clock; every input changes on the rising edge.
*/
`timescale 1ns/1ns
module fdma_ctrl_bench
  import fdma_pkg::*;
;
  logic clk;
  logic reset_n;
  logic [N_EVT-1:0] sync_event;
  logic [N_CH-1:0] cfg_start, cfg_sync_en, cfg_pingpong, chan_irq, chan_active, chan_half;
  logic [N_CH-1:0][EVT_SEL_W-1:0] channel_sync_event_select;
  logic [N_CH-1:0][ADDR_W-1:0] cfg_src_addr, cfg_dst_addr, cfg_dst_addr_b;
  logic [N_CH-1:0][COUNT_W-1:0] cfg_count;
  logic clk_idle_req, mem_req, mem_we, mem_ack, idle_ack;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0] lat;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int irq_seen [N_CH] = '{default: 0};
  fdma_ctrl dut (.clk(clk), .reset_n(reset_n), .sync_event(sync_event),
    .cfg_start(cfg_start), .cfg_sync_en(cfg_sync_en), .cfg_pingpong(cfg_pingpong),
    .channel_sync_event_select(channel_sync_event_select), .cfg_src_addr(cfg_src_addr),
    .cfg_dst_addr(cfg_dst_addr), .cfg_dst_addr_b(cfg_dst_addr_b), .cfg_count(cfg_count),
    .clk_idle_req(clk_idle_req), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .chan_irq(chan_irq),
    .chan_active(chan_active), .chan_half(chan_half), .idle_ack(idle_ack));
  fdma_mem_model mem (.clk(clk), .reset_n(reset_n), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'h5A5A;
  endfunction
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(input int ch, input logic [15:0] src, dst, cnt);
    @(posedge clk);
    cfg_src_addr[ch] <= src;
    cfg_dst_addr[ch] <= dst;
    cfg_count[ch] <= cnt;
    cfg_start[ch] <= 1'b1;
    @(posedge clk);
    cfg_start[ch] <= 1'b0;
  endtask
  task automatic wait_irq(input int ch, input int n);
    int k;
    k = 0;
    while (irq_seen[ch] < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    check("completions", 16'(n), 16'(irq_seen[ch]));
  endtask
  task automatic block(input logic [15:0] src, dst, cnt);
    for (int i = 0; i < cnt; i++) begin
      check("copied word", pat(src + 16'(i)), mem.store[dst + 16'(i)]);
    end
  endtask
  task automatic pulse(input int idx);
    @(posedge clk);
    sync_event[idx] <= 1'b1;
    @(posedge clk);
    sync_event[idx] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_basic();
    start(0, 16'h0100, 16'h0200, 16'h0003);
    wait_irq(0, 1);
    block(16'h0100, 16'h0200, 16'h0003);
    repeat (5) @(posedge clk);
    check("single pulse", 16'h0001, 16'(irq_seen[0]));
    check("active", 16'h0000, 16'(chan_active[0]));
  endtask
  task automatic t_all();
    lat <= 4'h2;
    for (int c = 0; c < N_CH; c++) start(c, 16'h1000 + 16'(c * 256), 16'h2000 + 16'(c * 256), 16'h0004);
    for (int c = 0; c < N_CH; c++) wait_irq(c, (c == 0) ? 2 : 1);
    for (int c = 0; c < N_CH; c++) block(16'h1000 + 16'(c * 256), 16'h2000 + 16'(c * 256), 16'h0004);
    lat <= 4'h0;
  endtask
  task automatic t_sync();
    cfg_sync_en[1] <= 1'b1;
    channel_sync_event_select[1] <= 5'h13;
    start(1, 16'h3000, 16'h3100, 16'h0002);
    pulse(5);
    check("unsynced word", pat(16'h3100), mem.store[16'h3100]);
    pulse(19);
    check("first synced", pat(16'h3000), mem.store[16'h3100]);
    check("second held", pat(16'h3101), mem.store[16'h3101]);
    pulse(19);
    wait_irq(1, 2);
    check("second synced", pat(16'h3001), mem.store[16'h3101]);
    cfg_sync_en[1] <= 1'b0;
  endtask
  task automatic t_pingpong();
    cfg_pingpong[2] <= 1'b1;
    cfg_dst_addr_b[2] <= 16'h4200;
    start(2, 16'h4000, 16'h4100, 16'h0002);
    wait_irq(2, 2);
    cfg_pingpong[2] <= 1'b0;
    check("half", 16'h0001, 16'(chan_half[2]));
    block(16'h4000, 16'h4100, 16'h0002);
    wait_irq(2, 3);
    block(16'h4000, 16'h4200, 16'h0002);
    check("stopped", 16'h0000, 16'(chan_active[2]));
  endtask
  task automatic t_idle();
    clk_idle_req <= 1'b1;
    repeat (3) @(posedge clk);
    check("parked", 16'h0001, 16'(idle_ack));
    start(3, 16'h5000, 16'h5100, 16'h0001);
    repeat (10) @(posedge clk);
    check("held word", pat(16'h5100), mem.store[16'h5100]);
    clk_idle_req <= 1'b0;
    wait_irq(3, 2);
    block(16'h5000, 16'h5100, 16'h0001);
  endtask
  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    for (int i = 0; i < N_CH; i++) begin
      if (chan_irq[i] === 1'b1) irq_seen[i] <= irq_seen[i] + 1;
    end
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end
  initial begin
    reset_n = 1'b0;
    {sync_event, cfg_start, cfg_sync_en, cfg_pingpong, clk_idle_req, lat} = '0;
    channel_sync_event_select = '0;
    {cfg_src_addr, cfg_dst_addr, cfg_dst_addr_b, cfg_count} = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_basic();
    t_all();
    t_sync();
    t_pingpong();
    t_idle();
    results();
  end
endmodule
